// ### rtl/apo_pkg.sv
/*
 * Package for the analog power override register bank: register offsets,
 * field positions, reset values and the number of forced sub-blocks.
 * Assumes a byte-addressed APB with 32-bit data and one register per word.
 */
package apo_pkg;

    localparam int          REG_W          = 8;
    localparam int          ADDR_W         = 12;
    localparam int          N_BLOCKS       = 14;

    // Printed offsets are register indices; the byte address is four times the index.
    localparam logic [7:0]  IDX_LINE_TRIM  = 8'h21;
    localparam logic [7:0]  IDX_OVR_A      = 8'h22;
    localparam logic [7:0]  IDX_OVR_B      = 8'h23;
    localparam logic [7:0]  IDX_STATE_A    = 8'h24;
    localparam logic [7:0]  IDX_STATE_B    = 8'h25;
    localparam logic [7:0]  IDX_SEQ_STATUS = 8'h30;

    localparam logic [ADDR_W-1:0] ADDR_LINE_TRIM  = {2'h0, IDX_LINE_TRIM, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OVR_A      = {2'h0, IDX_OVR_A, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_OVR_B      = {2'h0, IDX_OVR_B, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATE_A    = {2'h0, IDX_STATE_A, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_STATE_B    = {2'h0, IDX_STATE_B, 2'h0};
    localparam logic [ADDR_W-1:0] ADDR_SEQ_STATUS = {2'h0, IDX_SEQ_STATUS, 2'h0};

    localparam logic [REG_W-1:0] RST_LINE_TRIM = 8'h03;
    localparam logic [REG_W-1:0] RST_OVR_A     = 8'h00;
    localparam logic [REG_W-1:0] RST_OVR_B     = 8'h00;
    localparam logic [REG_W-1:0] RST_STATE_A   = 8'h00;
    localparam logic [REG_W-1:0] RST_STATE_B   = 8'h00;

    // Line test trim fields.
    localparam int LOAD_CTRL_BIT0 = 3;
    localparam int LOAD_CTRL_BIT1 = 2;
    localparam int SLEW_CTRL_BIT0 = 1;
    localparam int SLEW_CTRL_BIT1 = 0;

    // Bank A fields (override and state share positions).
    localparam int A_BIAS_REF    = 5;
    localparam int A_DAC         = 4;
    localparam int A_DRIVER      = 3;
    localparam int A_BIAS        = 2;
    localparam int A_CM_FEEDBACK = 1;
    localparam int A_OUTSTAGE    = 0;
    localparam int A_USED        = 6;

    // Bank B fields.
    localparam int B_GAIN        = 7;
    localparam int B_MUTE        = 6;
    localparam int B_MUTE_DUMMY  = 5;
    localparam int B_CHARGE_PUMP = 4;
    localparam int B_OFFSET_CAL  = 3;
    localparam int B_SHORT_PROT  = 2;
    localparam int B_IMP_SENSE   = 1;
    localparam int B_IMP_WHOLE   = 0;

    localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

endpackage

// ### rtl/apo_reg_cell.sv
/*
 * One 8-bit read/write register with a byte-lane write and a reset value.
 * Assumes the write strobe is a single-cycle pulse on the register clock.
 */
`timescale 1ns/1ps
`default_nettype none

module apo_reg_cell
    import apo_pkg::*;
#(
    parameter logic [REG_W-1:0] RESET_VAL = 8'h00
)
(
    // Clock and reset
    input  wire logic             clock_i,
    input  wire logic             rstn_i,
    // Write port
    input  wire logic             wr_i,
    input  wire logic [REG_W-1:0] wdata_i,
    // Stored value
    output logic      [REG_W-1:0] value_o
);

    logic [REG_W-1:0] value_r;

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            value_r <= RESET_VAL;
        end
        else if (wr_i)
        begin
            value_r <= wdata_i;
        end
    end

    assign value_o = value_r;

endmodule

`default_nettype wire

// ### rtl/apo_power_mux.sv
/*
 * Per-block choice between the sequenced power control and a forced level.
 * Assumes the sequenced controls come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module apo_power_mux
    import apo_pkg::*;
(
    // Clock and reset
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    // Selection inputs
    input  wire logic [N_BLOCKS-1:0] force_i,
    input  wire logic [N_BLOCKS-1:0] level_i,
    input  wire logic [N_BLOCKS-1:0] seq_pwr_up_i,
    // Effective power-up per block
    output logic      [N_BLOCKS-1:0] pwr_up_o
);

    logic [N_BLOCKS-1:0] pwr_up_nxt;
    logic [N_BLOCKS-1:0] pwr_up_r;

    // One selector per block; the vector is then held in a single register process.
    genvar g;
    generate
        for (g = 0; g < N_BLOCKS; g++)
        begin : g_blk
            assign pwr_up_nxt[g] = force_i[g] ? level_i[g] : seq_pwr_up_i[g];
        end
    endgenerate

    // Registered so the analog enables never glitch while a bank is rewritten.
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pwr_up_r <= '0;
        end
        else
        begin
            pwr_up_r <= pwr_up_nxt;
        end
    end

    assign pwr_up_o = pwr_up_r;

endmodule

`default_nettype wire

// ### rtl/analog_power_override_regs.sv
/*
 * APB register bank for left-channel line test trims and forced power
 * states of the left analog sub-blocks, bias reference and charge pump.
 * Assumes an APB master on clock_i and a power sequencer on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none

module analog_power_override_regs
    import apo_pkg::*;
(
    // Clock and reset
    input  wire logic                clock_i,
    input  wire logic                rstn_i,
    // APB slave
    input  wire logic                psel_i,
    input  wire logic                penable_i,
    input  wire logic                pwrite_i,
    input  wire logic [ADDR_W-1:0]   paddr_i,
    input  wire logic [31:0]         pwdata_i,
    input  wire logic [3:0]          pstrb_i,
    output logic      [31:0]         prdata_o,
    output logic                     pready_o,
    output logic                     pslverr_o,
    // Sequenced power controls
    input  wire logic [N_BLOCKS-1:0] seq_pwr_up_i,
    // Line test trims
    output logic      [1:0]          load_ctrl_o,
    output logic      [1:0]          slew_ctrl_o,
    // Effective power-up per block, bank B in 13..6, bank A in 5..0
    output logic      [N_BLOCKS-1:0] pwr_up_o
);

    logic             access;
    logic             wr_en;
    logic             hit_trim;
    logic             hit_ovr_a;
    logic             hit_ovr_b;
    logic             hit_st_a;
    logic             hit_st_b;
    logic             hit_status;
    logic             mapped;
    logic [REG_W-1:0] trim_q;
    logic [REG_W-1:0] ovr_a_q;
    logic [REG_W-1:0] ovr_b_q;
    logic [REG_W-1:0] st_a_q;
    logic [REG_W-1:0] st_b_q;
    logic [31:0]      rdata_nxt;
    logic [31:0]      prdata_r;
    logic             pslverr_r;
    logic [N_BLOCKS-1:0] force_vec;
    logic [N_BLOCKS-1:0] level_vec;
    logic [N_BLOCKS-1:0] pwr_up;

    // Zero-wait slave: every access completes in its first access cycle.
    assign access     = psel_i && penable_i;
    assign hit_trim   = (paddr_i == ADDR_LINE_TRIM);
    assign hit_ovr_a  = (paddr_i == ADDR_OVR_A);
    assign hit_ovr_b  = (paddr_i == ADDR_OVR_B);
    assign hit_st_a   = (paddr_i == ADDR_STATE_A);
    assign hit_st_b   = (paddr_i == ADDR_STATE_B);
    assign hit_status = (paddr_i == ADDR_SEQ_STATUS);
    assign mapped     = hit_trim || hit_ovr_a || hit_ovr_b || hit_st_a || hit_st_b || hit_status;
    // Only byte lane 0 holds data; a write without it leaves the register alone.
    assign wr_en      = access && pwrite_i && pstrb_i[0];

    // Whole bytes are stored, so reserved bits keep what was written.
    apo_reg_cell #(.RESET_VAL(RST_LINE_TRIM)) u_trim
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .wr_i    (wr_en && hit_trim),
        .wdata_i (pwdata_i[REG_W-1:0]),
        .value_o (trim_q)
    );

    apo_reg_cell #(.RESET_VAL(RST_OVR_A)) u_ovr_a
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .wr_i    (wr_en && hit_ovr_a),
        .wdata_i (pwdata_i[REG_W-1:0]),
        .value_o (ovr_a_q)
    );

    apo_reg_cell #(.RESET_VAL(RST_OVR_B)) u_ovr_b
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .wr_i    (wr_en && hit_ovr_b),
        .wdata_i (pwdata_i[REG_W-1:0]),
        .value_o (ovr_b_q)
    );

    apo_reg_cell #(.RESET_VAL(RST_STATE_A)) u_st_a
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .wr_i    (wr_en && hit_st_a),
        .wdata_i (pwdata_i[REG_W-1:0]),
        .value_o (st_a_q)
    );

    apo_reg_cell #(.RESET_VAL(RST_STATE_B)) u_st_b
    (
        .clock_i (clock_i),
        .rstn_i  (rstn_i),
        .wr_i    (wr_en && hit_st_b),
        .wdata_i (pwdata_i[REG_W-1:0]),
        .value_o (st_b_q)
    );

    assign load_ctrl_o = {trim_q[LOAD_CTRL_BIT1], trim_q[LOAD_CTRL_BIT0]};
    assign slew_ctrl_o = {trim_q[SLEW_CTRL_BIT1], trim_q[SLEW_CTRL_BIT0]};

    assign force_vec = {ovr_b_q, ovr_a_q[A_USED-1:0]};
    assign level_vec = {st_b_q, st_a_q[A_USED-1:0]};

    apo_power_mux u_mux
    (
        .clock_i      (clock_i),
        .rstn_i       (rstn_i),
        .force_i      (force_vec),
        .level_i      (level_vec),
        .seq_pwr_up_i (seq_pwr_up_i),
        .pwr_up_o     (pwr_up)
    );

    assign pwr_up_o = pwr_up;

    always_comb
    begin
        rdata_nxt = DATA_ZERO;
        unique case (1'b1)
            hit_trim:   rdata_nxt[REG_W-1:0] = trim_q;
            hit_ovr_a:  rdata_nxt[REG_W-1:0] = ovr_a_q;
            hit_ovr_b:  rdata_nxt[REG_W-1:0] = ovr_b_q;
            hit_st_a:   rdata_nxt[REG_W-1:0] = st_a_q;
            hit_st_b:   rdata_nxt[REG_W-1:0] = st_b_q;
            hit_status: rdata_nxt[N_BLOCKS-1:0] = pwr_up;
            default:    rdata_nxt = DATA_ZERO;
        endcase
    end

    // Read data is registered at the setup cycle so it is stable in the access cycle.
    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            prdata_r <= DATA_ZERO;
        end
        else if (psel_i && !penable_i && !pwrite_i)
        begin
            prdata_r <= rdata_nxt;
        end
    end

    always_ff @(posedge clock_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pslverr_r <= 1'b0;
        end
        else if (psel_i && !penable_i)
        begin
            // The status word cannot be written; unmapped addresses also error.
            pslverr_r <= !mapped || (pwrite_i && hit_status);
        end
    end

    assign prdata_o  = prdata_r;
    assign pready_o  = 1'b1;
    assign pslverr_o = pslverr_r && access;

endmodule

`default_nettype wire

// ### sim/apo_chk_sva.sv
/* Checker for the power override register bank.
   Sees only the top module's ports and shadows the five registers from APB writes. */
`timescale 1ns/1ps
`default_nettype none
module apo_chk
    import apo_pkg::*;
(
    input wire logic                clock_i,
    input wire logic                rstn_i,
    input wire logic                psel_i,
    input wire logic                penable_i,
    input wire logic                pwrite_i,
    input wire logic [ADDR_W-1:0]   paddr_i,
    input wire logic [31:0]         pwdata_i,
    input wire logic [3:0]          pstrb_i,
    input wire logic [31:0]         prdata_o,
    input wire logic                pready_o,
    input wire logic                pslverr_o,
    input wire logic [N_BLOCKS-1:0] seq_pwr_up_i,
    input wire logic [1:0]          load_ctrl_o,
    input wire logic [1:0]          slew_ctrl_o,
    input wire logic [N_BLOCKS-1:0] pwr_up_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    logic [7:0]          shd_r [5];
    logic [N_BLOCKS-1:0] exp_r;
    logic [ADDR_W-1:0]   off;
    logic                acc;
    logic                hit;
    logic                stat;
    logic [N_BLOCKS-1:0] ovr;
    logic [N_BLOCKS-1:0] lvl;
    assign acc = psel_i & penable_i;
    assign off = paddr_i - ADDR_LINE_TRIM;
    assign hit = (off < 12'h014) && (off[1:0] == 2'h0);
    assign stat = paddr_i == ADDR_SEQ_STATUS;
    assign ovr = {shd_r[2], shd_r[1][5:0]};
    assign lvl = {shd_r[4], shd_r[3][5:0]};
    // The shadow uses the bank's own write condition, so any drift points at the bank.
    always_ff @(posedge clock_i or negedge rstn_i)
        if (!rstn_i)
            shd_r <= '{8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
        else if (acc && pwrite_i && pstrb_i[0] && hit)
            shd_r[off[4:2]] <= pwdata_i[7:0];
    always_ff @(posedge clock_i or negedge rstn_i)
        if (!rstn_i)
            exp_r <= 14'h0000;
        else
            exp_r <= (ovr & lvl) | (~ovr & seq_pwr_up_i);
    a_ready_high: assert property (pready_o) else $error("ready low");
    a_trim_fields: assert property ({load_ctrl_o, slew_ctrl_o} == {shd_r[0][2], shd_r[0][3], shd_r[0][0], shd_r[0][1]})
        else $error("trim outputs differ");
    a_trim_reset: assert property ($rose(rstn_i) |-> load_ctrl_o == 2'h0 && slew_ctrl_o == 2'h3)
        else $error("trim reset value wrong");
    a_read_back: assert property (acc && hit && !pwrite_i |-> prdata_o == {24'h000000, shd_r[off[4:2]]})
        else $error("read data differs");
    a_power_mux: assert property (pwr_up_o == exp_r)
        else $error("power-up output wrong");
    a_status_read: assert property (acc && stat && !pwrite_i |-> prdata_o == {18'h0, $past(pwr_up_o)})
        else $error("status read differs");
    a_bad_error: assert property (acc && !hit && !(stat && !pwrite_i) |-> pslverr_o) else $error("no error");
    a_bad_silent: assert property (acc && !hit && !stat && !pwrite_i |-> prdata_o == DATA_ZERO) else $error("data");
    a_good_quiet: assert property (acc && hit |-> !pslverr_o) else $error("error on good access");
    a_idle_quiet: assert property (!acc |-> !pslverr_o) else $error("error outside access");
    c_trim_write: cover property (acc && pwrite_i && hit && off[4:2] == 3'h0);
    c_forced: cover property (|(ovr & (lvl ^ seq_pwr_up_i)));
    c_refused: cover property (acc && pslverr_o);
endmodule
bind analog_power_override_regs apo_chk i_chk (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .seq_pwr_up_i(seq_pwr_up_i),
    .load_ctrl_o(load_ctrl_o), .slew_ctrl_o(slew_ctrl_o), .pwr_up_o(pwr_up_o));
`default_nettype wire

// ### sim/analog_power_override_regs_tb.sv
/* Self-checking bench for the power override register bank.
   Drives APB and the sequencer input itself; the checker is bound in. */
`timescale 1ns/1ps
`default_nettype none
module analog_power_override_regs_tb
    import apo_pkg::*;
;
    logic clock_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [ADDR_W-1:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0;
    logic [3:0] pstrb_i = 4'h0;
    logic [N_BLOCKS-1:0] seq_pwr_up_i = 14'h2A5A;
    logic [31:0] prdata_o;
    logic pready_o;
    logic pslverr_o;
    logic [1:0] load_ctrl_o;
    logic [1:0] slew_ctrl_o;
    logic [N_BLOCKS-1:0] pwr_up_o;
    logic [31:0] rd;
    logic er;
    int err_count = 0;
    int cmp_count = 0;
    logic [ADDR_W-1:0] tab [5] = '{ADDR_LINE_TRIM, ADDR_OVR_A, ADDR_OVR_B, ADDR_STATE_A, ADDR_STATE_B};
    always #2.5 clock_i = ~clock_i;
    analog_power_override_regs i_dut (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .prdata_o(prdata_o),
        .pready_o(pready_o), .pslverr_o(pslverr_o), .seq_pwr_up_i(seq_pwr_up_i), .load_ctrl_o(load_ctrl_o),
        .slew_ctrl_o(slew_ctrl_o), .pwr_up_o(pwr_up_o));
    task automatic results();
        $display("compares %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Leaves psel high so a following call makes a back-to-back transfer.
    task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] s);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clock_i);
        penable_i <= 1'b1;
        do
            @(posedge clock_i);
        while (pready_o !== 1'b1);
        rd = prdata_o;
        er = pslverr_o;
    endtask
    task automatic idle(input int n);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
        repeat (n) @(posedge clock_i);
    endtask
    task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input logic e);
        apb(1'b0, a, DATA_ZERO, 4'h0);
        chk(rd, exp);
        chk({31'h0, er}, {31'h0, e});
    endtask
    task automatic t_reset();
        for (int i = 0; i < 5; i++)
            rdc(tab[i], (i == 0) ? 32'h0000_0003 : DATA_ZERO, 1'b0);
        idle(1);
        chk({28'h0, load_ctrl_o, slew_ctrl_o}, 32'h0000_0003);
        chk({18'h0, pwr_up_o}, {18'h0, seq_pwr_up_i});
    endtask
    task automatic t_rw();
        for (int i = 0; i < 5; i++)
        begin
            apb(1'b1, tab[i], 32'hFFFF_FF00 | (32'h0000_00C5 ^ i), 4'hF);
            rdc(tab[i], 32'h0000_00C5 ^ i, 1'b0);
        end
        apb(1'b1, ADDR_LINE_TRIM, 32'h0000_000A, 4'h1);
        idle(1);
        chk({28'h0, load_ctrl_o, slew_ctrl_o}, 32'h0000_0005);
    endtask
    task automatic t_force();
        logic [N_BLOCKS-1:0] pw;
        apb(1'b1, ADDR_OVR_A, 32'h0000_0035, 4'hF);
        apb(1'b1, ADDR_OVR_B, 32'h0000_00B3, 4'hF);
        apb(1'b1, ADDR_STATE_A, 32'h0000_001C, 4'hF);
        apb(1'b1, ADDR_STATE_B, 32'h0000_005A, 4'hF);
        for (int k = 0; k < 2; k++)
        begin
            idle(2);
            // Forced mask is {B3, 35[5:0]} = 2CF5, forced levels {5A, 1C[5:0]} = 169C.
            pw = (14'h2CF5 & 14'h169C) | (~14'h2CF5 & seq_pwr_up_i);
            chk({18'h0, pwr_up_o}, {18'h0, pw});
            rdc(ADDR_SEQ_STATUS, {18'h0, pw}, 1'b0);
            seq_pwr_up_i <= ~seq_pwr_up_i;
        end
    endtask
    // Refused accesses must leave the bank untouched.
    task automatic t_refuse();
        apb(1'b1, 12'h200, 32'h0000_00FF, 4'hF);
        chk({31'h0, er}, 32'h1);
        rdc(12'h200, DATA_ZERO, 1'b1);
        apb(1'b1, ADDR_SEQ_STATUS, 32'h0000_00FF, 4'hF);
        chk({31'h0, er}, 32'h1);
        apb(1'b1, ADDR_OVR_A, 32'h0000_00FF, 4'h0);
        rdc(ADDR_OVR_A, 32'h0000_0035, 1'b0);
    endtask
    task automatic t_midreset();
        idle(1);
        rstn_i <= 1'b0;
        idle(2);
        rstn_i <= 1'b1;
        rdc(ADDR_OVR_B, DATA_ZERO, 1'b0);
        rdc(ADDR_LINE_TRIM, 32'h0000_0003, 1'b0);
    endtask
    initial
    begin
        repeat (2) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_reset();
        t_rw();
        t_force();
        t_refuse();
        t_midreset();
        idle(1);
        results();
    end
    initial
    begin
        repeat (2000) @(posedge clock_i);
        err_count++;
        results();
    end
endmodule
`default_nettype wire
